// ---- rtl/rtc_pkg.sv ----
// Shared constants and types for the calendar / compare timer block
package rtc_pkg;
  // Register offsets
  localparam logic [3:0] RA_SEC  = 4'h0;
  localparam logic [3:0] RA_MIN  = 4'h1;
  localparam logic [3:0] RA_HR   = 4'h2;
  localparam logic [3:0] RA_WK   = 4'h3;
  localparam logic [3:0] RA_DAY  = 4'h4;
  localparam logic [3:0] RA_MON  = 4'h5;
  localparam logic [3:0] RA_YR   = 4'h6;
  localparam logic [3:0] RA_CTRL = 4'h7;
  localparam logic [3:0] RA_OSEL = 4'h8;
  localparam logic [3:0] RA_CORR = 4'h9;
  localparam logic [3:0] RA_PCFG = 4'hA;
  localparam logic [3:0] RA_AMIN = 4'hB;
  localparam logic [3:0] RA_AHR  = 4'hC;
  localparam logic [3:0] RA_AWK  = 4'hD;
  localparam logic [3:0] RA_SADJ = 4'hE;
  // Control and correction register bit positions
  localparam int CB_RUN  = 0;
  localparam int CB_MODE = 1;
  localparam int CB_H24  = 2;
  localparam int CB_PM   = 3;
  localparam int CB_SRST = 4;
  localparam int CB_CLEAR_ON_MATCH_BIT = 5;
  localparam int CB_AADJ = 6;
  localparam int CORR_GO = 7;
  localparam int CORR_SLOW = 6;
  // Reset and limit values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE  = 8'h01;
  localparam logic [7:0] SEC_MAX  = 8'h59;
  localparam logic [7:0] HALF_MIN = 8'h30;
  localparam logic [7:0] H24_MAX  = 8'h23;
  localparam logic [7:0] H12_MAX  = 8'h11;
  localparam logic [7:0] MON_MAX  = 8'h12;
  localparam logic [7:0] YR_MAX   = 8'h99;
  localparam logic [2:0] WK_MAX   = 3'h6;
  // Output pin selections
  localparam logic [2:0] PS_GPO = 3'h0;
  localparam logic [2:0] PS_TGL = 3'h5;
  localparam logic [2:0] PS_64  = 3'h6;
  localparam logic [2:0] PS_SUB = 3'h7;
  // Prescaler: exponent of each compare count source
  localparam int PRE_W = 13;
  localparam logic [7:0][3:0] PRE_EXP = {4'hD, 4'hC, 4'hB, 4'h9, 4'h8, 4'h7, 4'h5, 4'h3};

  typedef struct packed {
    logic periodic;
    logic alarm;
    logic cmp;
    logic ovf;
  } rtc_ev_s;

  function automatic logic [7:0] rtc_days(input logic [7:0] mon, input logic leap);
    unique case (mon)
      8'h02:                      rtc_days = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: rtc_days = 8'h30;
      default:                    rtc_days = 8'h31;
    endcase
  endfunction
endpackage

// ---- rtl/rtc_cnt.sv ----
// Binary counter stage with clear, load and carry out
`timescale 1ns/10ps
module rtc_cnt #(
  parameter int W = 8
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_en,
  input  wire logic         i_clr,
  input  wire logic         i_ld,
  input  wire logic [W-1:0] i_val,
  output logic      [W-1:0] o_q,
  output logic              o_carry
);
  assign o_carry = i_en && (&o_q);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_clr) begin
      o_q <= '0;
    end else if (i_ld) begin
      o_q <= i_val;
    end else if (i_en) begin
      o_q <= W'(o_q + 1'b1);
    end
  end
endmodule // rtc_cnt

// ---- rtl/rtc_bcd.sv ----
// Two-digit BCD field with wrap between minimum and maximum
`timescale 1ns/10ps
module rtc_bcd #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_clr,
  input  wire logic       i_inc,
  input  wire logic       i_ld,
  input  wire logic [7:0] i_ld_val,
  input  wire logic [7:0] i_min,
  input  wire logic [7:0] i_max,
  output logic      [7:0] o_q,
  output logic            o_wrap
);
  logic [7:0] next_q;

  assign o_wrap = i_inc && (o_q >= i_max);

  always_comb begin
    if (o_wrap) begin
      next_q = i_min;
    end else if (o_q[3:0] >= 4'h9) begin
      next_q = {4'(o_q[7:4] + 4'h1), 4'h0};
    end else begin
      next_q = 8'(o_q + 8'h01);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_clr) begin
      o_q <= RST_VAL;
    end else if (i_ld) begin
      o_q <= i_ld_val;
    end else if (i_inc) begin
      o_q <= next_q;
    end
  end
endmodule // rtc_bcd

// ---- rtl/rtc_timer.sv ----
// Calendar clock and compare-match timer with register port
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module rtc_timer
  import rtc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_subclock_input,
  output logic      [7:0] o_rdata,
  output rtc_ev_s         o_ev,
  output logic            o_timer_output_pin
);
  logic [7:0]       ctrl, osel, corr, pcfg, amin, ahr, cmpv;
  logic [2:0]       awk, wk, stall_src;
  logic [5:0]       stall;
  logic [PRE_W-1:0] pre;
  logic [7:0]       c8_q, sec, mn, hr, day, mon, yr, rd_val;
  logic [3:0]       c4_q;
  logic [2:0]       c3_q;
  logic             sub_q, sub_tick, run, cmp, h24, clear_on_match_bit, srst, wr_ok;
  logic             pre_tick, cnt_step, match, match_ev, c8_carry, c4_carry;
  logic             sec_tick, sec_wrap, min_inc, min_wrap, hr_wrap, day_inc;
  logic             day_wrap, mon_wrap, leap, corr_pend, corr_now, adj30;
  logic             update_in_progress_flag, match_al, al_q, tgl, per_ev;
  logic [7:0]       per_vec;

  assign run  = ctrl[CB_RUN];
  assign cmp  = ctrl[CB_MODE];
  assign h24  = ctrl[CB_H24];
  assign clear_on_match_bit = ctrl[CB_CLEAR_ON_MATCH_BIT];
  assign srst = i_wr && (i_addr == RA_CTRL) && i_wdata[CB_SRST];
  assign update_in_progress_flag = !cmp && run && (&{c3_q, c4_q, c8_q});
  assign wr_ok = i_wr && !update_in_progress_flag && !cmp;
  assign sub_tick = i_subclock_input && !sub_q;

  // Prescaled count source for compare mode
  assign pre_tick = &(pre | ({PRE_W{1'b1}} << PRE_EXP[osel[6:4]]));
  assign cnt_step = run && cmp && pre_tick;
  assign match    = (c8_q == cmpv);
  assign match_ev = cnt_step && match;

  // Software correction request waits for the next second
  assign corr_now = sec_tick && (corr_pend || (ctrl[CB_AADJ] && sec_wrap));
  assign adj30    = wr_ok && (i_addr == RA_SADJ) && i_wdata[1] && (sec >= HALF_MIN);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sub_q <= 1'b0;
      pre   <= '0;
    end else begin
      sub_q <= i_subclock_input;
      pre   <= PRE_W'(pre + 1'b1);
    end
  end

  // Divider chain: 8 + 4 + 3 bits = 32768 in calendar mode
  rtc_cnt #(.W(8)) u_c8 (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_en      (cmp ? cnt_step : (run && sub_tick && stall == 6'h00)),
    .i_clr     (srst || (match_ev && clear_on_match_bit)),
    .i_ld      (corr_now && !corr[CORR_SLOW]),
    .i_val     ({2'b00, corr[5:0]}),
    .o_q       (c8_q),
    .o_carry   (c8_carry)
  );
  rtc_cnt #(.W(4)) u_c4 (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_en      (c8_carry && !cmp),
    .i_clr     (srst),
    .i_ld      (1'b0),
    .i_val     (4'h0),
    .o_q       (c4_q),
    .o_carry   (c4_carry)
  );
  rtc_cnt #(.W(3)) u_c3 (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_en      (c4_carry),
    .i_clr     (srst),
    .i_ld      (1'b0),
    .i_val     (3'h0),
    .o_q       (c3_q),
    .o_carry   (sec_tick)
  );

  // Slow correction swallows subclock edges
  assign stall_src = 3'(corr_now && corr[CORR_SLOW]);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || srst) begin
      stall     <= 6'h00;
      corr_pend <= 1'b0;
    end else begin
      if (stall_src[0]) begin
        stall <= corr[5:0];
      end else if (sub_tick && stall != 6'h00) begin
        stall <= 6'(stall - 6'h01);
      end
      if (wr_ok && i_addr == RA_CORR && i_wdata[CORR_GO]) begin
        corr_pend <= 1'b1;
      end else if (sec_tick) begin
        corr_pend <= 1'b0;
      end
    end
  end

  // Calendar fields, BCD
  rtc_bcd #(.RST_VAL(BCD_ZERO)) u_sec (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clr     (srst),
    .i_inc     (sec_tick && !cmp),
    .i_ld      (wr_ok && (i_addr == RA_SEC || (i_addr == RA_SADJ && |i_wdata[1:0]))),
    .i_ld_val  (i_addr == RA_SEC ? i_wdata : BCD_ZERO),
    .i_min     (BCD_ZERO),
    .i_max     (SEC_MAX),
    .o_q       (sec),
    .o_wrap    (sec_wrap)
  );
  assign min_inc = sec_wrap || adj30;
  rtc_bcd #(.RST_VAL(BCD_ZERO)) u_min (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clr     (srst),
    .i_inc     (min_inc),
    .i_ld      (wr_ok && i_addr == RA_MIN),
    .i_ld_val  (i_wdata),
    .i_min     (BCD_ZERO),
    .i_max     (SEC_MAX),
    .o_q       (mn),
    .o_wrap    (min_wrap)
  );
  rtc_bcd #(.RST_VAL(BCD_ZERO)) u_hr (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clr     (srst),
    .i_inc     (min_wrap),
    .i_ld      (wr_ok && i_addr == RA_HR),
    .i_ld_val  (i_wdata),
    .i_min     (BCD_ZERO),
    .i_max     (h24 ? H24_MAX : H12_MAX),
    .o_q       (hr),
    .o_wrap    (hr_wrap)
  );
  assign day_inc = hr_wrap && (h24 || ctrl[CB_PM]);
  assign leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                      : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
  rtc_bcd #(.RST_VAL(BCD_ONE)) u_day (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clr     (srst),
    .i_inc     (day_inc),
    .i_ld      (wr_ok && i_addr == RA_DAY),
    .i_ld_val  (i_wdata),
    .i_min     (BCD_ONE),
    .i_max     (rtc_days(mon, leap)),
    .o_q       (day),
    .o_wrap    (day_wrap)
  );
  rtc_bcd #(.RST_VAL(BCD_ONE)) u_mon (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clr     (srst),
    .i_inc     (day_wrap),
    .i_ld      (wr_ok && i_addr == RA_MON),
    .i_ld_val  (i_wdata),
    .i_min     (BCD_ONE),
    .i_max     (MON_MAX),
    .o_q       (mon),
    .o_wrap    (mon_wrap)
  );
  rtc_bcd #(.RST_VAL(BCD_ZERO)) u_yr (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clr     (srst),
    .i_inc     (mon_wrap),
    .i_ld      (wr_ok && i_addr == RA_YR),
    .i_ld_val  (i_wdata),
    .i_min     (BCD_ZERO),
    .i_max     (YR_MAX),
    .o_q       (yr),
    .o_wrap    ()
  );

  // Weekday is plain binary
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || srst) begin
      wk <= 3'h0;
    end else if (wr_ok && i_addr == RA_WK) begin
      wk <= i_wdata[2:0];
    end else if (day_inc) begin
      wk <= (wk >= WK_MAX) ? 3'h0 : 3'(wk + 3'h1);
    end
  end

  // Software registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl <= CTRL_RST;
      osel <= 8'h00;
      corr <= 8'h00;
      pcfg <= 8'h00;
      amin <= 8'h00;
      ahr  <= 8'h00;
      awk  <= 3'h0;
      cmpv <= 8'h00;
    end else begin
      if (i_wr && i_addr == RA_CTRL) begin
        ctrl <= {1'b0, i_wdata[6:5], 1'b0, i_wdata[3:0]};
        if (update_in_progress_flag) begin
          ctrl[CB_PM] <= ctrl[CB_PM] ^ (hr_wrap && !h24);
        end
      end else if (hr_wrap && !h24) begin
        ctrl[CB_PM] <= !ctrl[CB_PM];
      end
      if (i_wr && i_addr == RA_OSEL) osel <= {1'b0, i_wdata[6:0]};
      if (wr_ok && i_addr == RA_CORR) corr <= {1'b0, i_wdata[6:0]};
      if (i_wr && i_addr == RA_PCFG) pcfg <= {1'b0, i_wdata[6:0]};
      if (wr_ok && i_addr == RA_AMIN) amin <= i_wdata;
      if (wr_ok && i_addr == RA_AHR) ahr <= i_wdata;
      if (wr_ok && i_addr == RA_AWK) awk <= i_wdata[2:0];
      if (i_wr && cmp && i_addr == RA_MIN) cmpv <= i_wdata;
    end
  end

  // Periodic and alarm events
  assign per_vec = {mon_wrap, day_wrap, day_inc, min_wrap, min_inc, sec_tick,
                    c4_carry && (&c3_q[1:0]), c4_carry && c3_q[0]};
  assign per_ev  = pcfg[3] && per_vec[pcfg[2:0]];
  assign match_al = !cmp && (|pcfg[6:4])
                    && (!pcfg[4] || mn == amin)
                    && (!pcfg[5] || {ctrl[CB_PM], hr[6:0]} == ahr)
                    && (!pcfg[6] || wk == awk);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      al_q <= 1'b0;
      o_ev <= '0;
    end else begin
      al_q          <= match_al;
      o_ev.periodic <= per_ev && !cmp;
      o_ev.alarm    <= match_al && !al_q;
      o_ev.cmp      <= match_ev;
      o_ev.ovf      <= cnt_step && (&c8_q) && !(match && clear_on_match_bit);
    end
  end

  // Output pin
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || srst) begin
      tgl <= 1'b0;
    end else if (match_ev && osel[2:0] == PS_TGL) begin
      tgl <= !tgl;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_timer_output_pin <= 1'b0;
    end else begin
      unique case (osel[2:0])
        PS_GPO: o_timer_output_pin <= osel[3];
        PS_TGL: o_timer_output_pin <= cmp ? tgl : c3_q[2];
        PS_64:  o_timer_output_pin <= cmp ? osel[3] : c4_q[0];
        PS_SUB: o_timer_output_pin <= sub_q;
        default: o_timer_output_pin <= pre[osel[2:0]];
      endcase
    end
  end

  // Read port
  always_comb begin
    unique case (i_addr)
      RA_SEC:  rd_val = cmp ? c8_q : {update_in_progress_flag, sec[6:0]};
      RA_MIN:  rd_val = cmp ? cmpv : mn;
      RA_HR:   rd_val = hr;
      RA_WK:   rd_val = {5'h00, wk};
      RA_DAY:  rd_val = day;
      RA_MON:  rd_val = mon;
      RA_YR:   rd_val = yr;
      RA_CTRL: rd_val = ctrl;
      RA_OSEL: rd_val = osel;
      RA_CORR: rd_val = {corr_pend, corr[6:0]};
      RA_PCFG: rd_val = pcfg;
      RA_AMIN: rd_val = amin;
      RA_AHR:  rd_val = ahr;
      RA_AWK:  rd_val = {5'h00, awk};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_val : 8'h00;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  property p_hold;
    !cmp && !run && !i_wr |=> $stable(sec) && $stable(c8_q);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while stopped");
  property p_sec_wrap;
    sec_tick && !cmp && sec == SEC_MAX && !i_wr |=> sec == BCD_ZERO;
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap");
  property p_srst;
    srst |=> sec == BCD_ZERO && c8_q == 8'h00 && day == BCD_ONE;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset ignored");
  property p_clr;
    match_ev && clear_on_match_bit |=> c8_q == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("no clear on match");
  property p_cont;
    match_ev && !clear_on_match_bit && !srst && c8_q != 8'hFF |=> c8_q == 8'($past(c8_q) + 8'h01);
  endproperty
  a_cont: assert property (p_cont) else $error("count stopped on match");
  property p_ovf;
    cnt_step && c8_q == 8'hFF && !(match && clear_on_match_bit) |=> o_ev.ovf;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow event missing");
  property p_tgl;
    match_ev && cmp && osel[2:0] == PS_TGL && !srst && !i_wr
      |-> ##2 o_timer_output_pin != $past(o_timer_output_pin);
  endproperty
  a_tgl: assert property (p_tgl) else $error("pin did not toggle");
  property p_leap;
    day_inc && day == 8'h28 && mon == 8'h02 && leap && !i_wr |=> day == 8'h29;
  endproperty
  a_leap: assert property (p_leap) else $error("leap day skipped");
  property p_busy;
    i_wr && i_addr == RA_SEC && update_in_progress_flag && !sec_tick
      |=> sec == $past(sec);
  endproperty
  a_busy: assert property (p_busy) else $error("write taken while busy");
  property p_alarm;
    match_al && !al_q |=> o_ev.alarm;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm event missing");

  c_match: cover property (match_ev && clear_on_match_bit);
  c_minute: cover property (sec_wrap && !cmp);
  c_alarm: cover property (o_ev.alarm);
endmodule // rtc_timer

// ---- tb/rtc_sub_src.sv ----
// Free-running subclock source for the timer under test
`timescale 1ns/10ps
module rtc_sub_src (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  output logic      o_sub
);
  // Crystal runs free; 32768 rising edges every 65536 clocks
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_sub <= 1'b0;
    end else begin
      o_sub <= ~o_sub;
    end
  end
endmodule // rtc_sub_src

// ---- tb/rtc_timer_test.sv ----
// Self-checking bench for the calendar / compare timer
`timescale 1ns/10ps
module rtc_timer_test;
  import rtc_pkg::*;
  logic       i_sys_clk = 1'b0;
  logic       i_rst_n   = 1'b0;
  logic [3:0] i_addr    = 4'h0;
  logic [7:0] i_wdata   = 8'h00;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  logic       sub;
  logic [7:0] o_rdata;
  rtc_ev_s    o_ev;
  logic       o_timer_output_pin;
  logic       pin_q = 1'b0;
  int         n_mismatch = 0;
  int         check_count = 0;
  int         n_per = 0, n_alm = 0, n_cmp = 0, n_ovf = 0, n_tgl = 0;
  int         p0, a0, c0, o0, t0, k;
  logic [7:0] v, w;
  logic [3:0] ra [9] = '{RA_SEC, RA_MIN, RA_HR, RA_WK, RA_DAY, RA_MON, RA_YR, RA_CTRL, 4'hF};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

  always #5 i_sys_clk = ~i_sys_clk;

  rtc_sub_src u_sub (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .o_sub(sub));

  rtc_timer u_dut (
    .i_sys_clk          (i_sys_clk),
    .i_rst_n            (i_rst_n),
    .i_addr             (i_addr),
    .i_wdata            (i_wdata),
    .i_wr               (i_wr),
    .i_rd               (i_rd),
    .i_subclock_input   (sub),
    .o_rdata            (o_rdata),
    .o_ev               (o_ev),
    .o_timer_output_pin (o_timer_output_pin)
  );

  // Event and pin activity counters
  always @(posedge i_sys_clk) begin
    if (o_ev.periodic === 1'b1) n_per++;
    if (o_ev.alarm === 1'b1) n_alm++;
    if (o_ev.cmp === 1'b1) n_cmp++;
    if (o_ev.ovf === 1'b1) n_ovf++;
    if (pin_q !== o_timer_output_pin) n_tgl++;
    pin_q <= o_timer_output_pin;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(nm, {8'h00, d}, {8'h00, exp});
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge i_sys_clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (k = 0; k < 9; k++) rchk("reset value", ra[k], rv[k]);
    done("reset");
    wr(RA_MIN, 8'h10);
    wr(RA_SEC, 8'h29);
    wr(RA_SADJ, 8'h02);
    rchk("round down sec", RA_SEC, 8'h00);
    rchk("round down min", RA_MIN, 8'h10);
    wr(RA_SEC, 8'h30);
    wr(RA_SADJ, 8'h02);
    rchk("round up sec", RA_SEC, 8'h00);
    rchk("round up min", RA_MIN, 8'h11);
    wr(RA_SEC, 8'h45);
    wr(RA_SADJ, 8'h01);
    rchk("sec reset", RA_SEC, 8'h00);
    rchk("sec reset min", RA_MIN, 8'h11);
    done("adjust");
    wr(RA_CTRL, 8'h08);
    rchk("afternoon bit", RA_CTRL, 8'h08);
    wr(RA_CTRL, 8'h10);
    rchk("soft reset ctrl", RA_CTRL, 8'h00);
    rchk("soft reset min", RA_MIN, 8'h00);
    wr(RA_OSEL, 8'h08);
    repeat (3) @(posedge i_sys_clk);
    chk("port high", o_timer_output_pin, 1'b1);
    wr(RA_OSEL, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    chk("port low", o_timer_output_pin, 1'b0);
    done("ctrl and pin");
    // Compare mode, clear on match at 3, toggle pin
    wr(RA_CTRL, 8'h22);
    wr(RA_MIN, 8'h03);
    wr(RA_OSEL, 8'h05);
    wr(RA_CTRL, 8'h23);
    repeat (40) @(posedge i_sys_clk);
    c0 = n_cmp;
    t0 = n_tgl;
    repeat (256) @(posedge i_sys_clk);
    chk("matches", n_cmp - c0, 16'd8);
    chk("pin toggles", n_tgl - t0, 16'd8);
    rd(RA_SEC, v);
    chk("count bound", v <= 8'h03, 1'b1);
    wr(RA_CTRL, 8'h03);
    c0 = n_cmp;
    o0 = n_ovf;
    repeat (4096) @(posedge i_sys_clk);
    chk("overflows", n_ovf - o0, 16'd2);
    chk("free matches", n_cmp - c0, 16'd2);
    wr(RA_CTRL, 8'h02);
    rd(RA_SEC, v);
    repeat (64) @(posedge i_sys_clk);
    rd(RA_SEC, w);
    chk("held count", w, v);
    wr(RA_CTRL, 8'h12);
    rchk("soft reset count", RA_SEC, 8'h00);
    // Slower source f32 with clear at 3: one match every 128 clocks
    wr(RA_OSEL, 8'h15);
    wr(RA_CTRL, 8'h23);
    c0 = n_cmp;
    repeat (260) @(posedge i_sys_clk);
    chk("f32 matches", n_cmp - c0, 16'd2);
    wr(RA_CTRL, 8'h22);
    wr(RA_OSEL, 8'h0E);
    repeat (3) @(posedge i_sys_clk);
    chk("compare port", o_timer_output_pin, 1'b1);
    done("compare");
    // Leap-day rollover at one second, 24-hour mode
    wr(RA_CTRL, 8'h14);
    wr(RA_CORR, 8'h85);
    rchk("corr pending", RA_CORR, 8'h85);
    wr(RA_HR, 8'h23);
    wr(RA_MIN, 8'h59);
    wr(RA_SEC, 8'h59);
    wr(RA_DAY, 8'h28);
    wr(RA_MON, 8'h02);
    wr(RA_YR, 8'h00);
    wr(RA_AMIN, 8'h00);
    wr(RA_AHR, 8'h00);
    wr(RA_PCFG, 8'h38);
    p0 = n_per;
    a0 = n_alm;
    wr(RA_CTRL, 8'h05);
    for (k = 0; k < 70000 && n_per - p0 < 4; k++) @(posedge i_sys_clk);
    repeat (20) @(posedge i_sys_clk);
    chk("quarter events", n_per - p0, 16'd4);
    rchk("sec", RA_SEC, 8'h00);
    rchk("min", RA_MIN, 8'h00);
    rchk("hour", RA_HR, 8'h00);
    rchk("leap day", RA_DAY, 8'h29);
    rchk("month", RA_MON, 8'h02);
    chk("alarm", n_alm - a0, 16'd1);
    rchk("corr applied", RA_CORR, 8'h05);
    done("calendar");
    conclude();
  end
endmodule // rtc_timer_test
